// [rtl/mcs_pkg.sv]
// constants for the main clock selector and prescaler
// Behaviour
// - two-bit select picks fast, ultra-low-power, crystal or external clock as main clock.
// - output bit 7 of control A drives the system clock onto the pin.
// - while asleep the pin carries no clock unless a peripheral uses it.
// - enabled prescaler divides by the ratio given by the four-bit code.
// - prescaler disabled means peripheral clock equals main clock undivided.
// - division code may change while running.
// - freeze bit blocks writes to both control registers and current calibration.
// - once frozen the lock register is inaccessible until hardware reset.
// - freeze bit is loaded from the fuse at reset.
// - status bit 7 reads one once the external clock has started.
// - stability bits 7:4 read one only while the source is requested.
// - switching flag reads one until the new source is stable and taken.
// - keep-running bit holds the fast oscillator running without users.
// - an unrequested oscillator gives no clock output even when running.
// - clock gate opens four oscillator cycles after the source reports ready; keep-running skips start-up.
// - after reset main clock is the fast oscillator and the peripheral clock is it divided by 6.
// - protected register changes only within four accesses after the key write.
package mcs_pkg;
  localparam logic [5:0] IDX_CTRL_A = 6'h00;
  localparam logic [5:0] IDX_CTRL_B = 6'h01;
  localparam logic [5:0] IDX_LOCK   = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_FCTL   = 6'h10;
  localparam logic [5:0] IDX_CAL_A  = 6'h11;
  localparam logic [5:0] IDX_CAL_B  = 6'h12;
  localparam logic [5:0] IDX_UCTL   = 6'h18;
  localparam logic [5:0] IDX_XCTL   = 6'h1c;
  localparam logic [5:0] IDX_KEY    = 6'h20;
  // key value is arbitrary
  localparam logic [7:0] PROT_KEY   = 8'h5a;
  localparam logic [2:0] KEY_WINDOW = 3'h4;
  localparam logic [1:0] GATE_EDGES = 2'h3;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h11;
  localparam logic [7:0] OSC_RST    = 8'h00;
  localparam logic [7:0] CTRL_A_MSK = 8'h83;
  localparam logic [7:0] CTRL_B_MSK = 8'h1f;
  localparam logic [7:0] RUN_MSK    = 8'h02;
  localparam logic [7:0] XCTL_MSK   = 8'h37;
  localparam int SYSCLOCK_PIN_OUTPUT_BIT = 7;
  localparam int PEN_BIT    = 0;
  localparam int FREEZE_BIT = 0;
  localparam int KEEP_BIT   = 1;
  localparam int XEN_BIT    = 0;
  localparam int CAL_LK_BIT = 7;
  localparam logic [1:0] SRC_FAST  = 2'h0;
  localparam logic [1:0] SRC_ULP   = 2'h1;
  localparam logic [1:0] SRC_XTAL  = 2'h2;
  localparam logic [1:0] SRC_EXT   = 2'h3;
endpackage : mcs_pkg

// [rtl/mcs_main_clock.sv]
// main clock source selection, prescaler, clock pin and register file
`timescale 1ns/1ps
module mcs_main_clock
  import mcs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  osc_clk_in,
  input  wire logic [3:0]  osc_ready_in,
  input  wire logic [3:0]  periph_req,
  input  wire logic        sleep_in,
  input  wire logic        sysclk_busy_in,
  input  wire logic        fuse_calibration_freeze,
  input  wire logic [6:0]  fuse_trim,
  input  wire logic [3:0]  fuse_slope,
  output logic [3:0]       osc_run_o,
  output logic [3:0]       osc_grant_o,
  output logic [1:0]       main_src_o,
  output logic             peripheral_clock_o,
  output logic             per_tick_o,
  output logic             sysclock_pin_output,
  output logic             sysclock_pin_oe,
  output logic [6:0]       fast_osc_trim_o,
  output logic [3:0]       fast_osc_temp_slope_o,
  output logic [7:0]       crystal_cfg_o
);

  typedef struct packed {
    logic [7:0]      ctrl_a;
    logic [7:0]      ctrl_b;
    logic            freeze;
    logic [7:0]      fctl;
    logic [6:0]      cal_a;
    logic [3:0]      cal_b;
    logic            cal_lock;
    logic [7:0]      uctl;
    logic [7:0]      xctl;
    logic [1:0]      active;
    logic [1:0]      target;
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [3:0]      s3;
    logic [3:0]      r1;
    logic [3:0]      r2;
    logic [3:0][1:0] gcnt;
    logic [3:0]      gate;
    logic [5:0]      div_cnt;
    logic            per_lvl;
    logic            per_tick;
    logic [2:0]      key_cnt;
    logic            ack;
    logic [7:0]      rdata;
    logic            init;
    logic            pin;
    logic            pin_oe;
  } mcs_state_t;

  mcs_state_t q;
  mcs_state_t d;

  logic [3:0] req;
  logic [3:0] edge_v;
  logic [3:0] keep;
  logic [3:0] stable;
  logic       bus_req;
  logic       acc;
  logic       prot_ok;
  logic [5:0] idx;
  logic [7:0] wd;

  // prescaler code to half period minus one, in main clock ticks
  function automatic logic [5:0] mcs_half(input logic [3:0] code);
    unique case (code)
      4'h0:    mcs_half = 6'h00;
      4'h1:    mcs_half = 6'h01;
      4'h2:    mcs_half = 6'h03;
      4'h3:    mcs_half = 6'h07;
      4'h4:    mcs_half = 6'h0f;
      4'h5:    mcs_half = 6'h1f;
      4'h8:    mcs_half = 6'h02;
      4'h9:    mcs_half = 6'h04;
      4'ha:    mcs_half = 6'h05;
      4'hb:    mcs_half = 6'h0b;
      4'hc:    mcs_half = 6'h17;
      default: mcs_half = 6'h00;
    endcase
  endfunction : mcs_half

  function automatic logic mcs_code_ok(input logic [3:0] code);
    mcs_code_ok = (code <= 4'h5) || ((code >= 4'h8) && (code <= 4'hc));
  endfunction : mcs_code_ok

  assign edge_v = q.s2 & ~q.s3;
  // external clock has no keep-running control
  assign keep = {1'b0, q.xctl[KEEP_BIT] & q.xctl[XEN_BIT],
                 q.uctl[KEEP_BIT], q.fctl[KEEP_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_src
      // the crystal only runs once software has enabled it
      assign req[gi] = ((q.active == 2'(gi)) || (q.target == 2'(gi)) ||
                        periph_req[gi]) &&
                       ((2'(gi) != SRC_XTAL) || q.xctl[XEN_BIT]);
      assign osc_run_o[gi]   = req[gi] | keep[gi];
      assign osc_grant_o[gi] = req[gi] & q.gate[gi];
      assign stable[gi]      = req[gi] & q.gate[gi];
    end
  endgenerate

  assign bus_req         = avs_read | avs_write;
  assign acc             = bus_req & q.ack;
  assign avs_waitrequest = bus_req & ~q.ack;
  assign avs_readdata    = {24'h000000, q.rdata};
  assign prot_ok         = (q.key_cnt != 3'h0);
  assign idx             = avs_address[7:2];
  assign wd              = avs_writedata[7:0];

  assign main_src_o            = q.active;
  assign peripheral_clock_o    = q.per_lvl;
  assign per_tick_o            = q.per_tick;
  assign sysclock_pin_output   = q.pin;
  assign sysclock_pin_oe       = q.pin_oe;
  assign fast_osc_trim_o       = q.cal_a;
  assign fast_osc_temp_slope_o = q.cal_b;
  assign crystal_cfg_o         = q.xctl;

  always_comb begin
    d = q;
    d.s1 = osc_clk_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.r1 = osc_ready_in;
    d.r2 = q.r1;
    d.per_tick = 1'b0;
    // fuses are captured in the first cycle after reset release
    if (!q.init) begin
      d.init     = 1'b1;
      d.freeze   = fuse_calibration_freeze;
      d.cal_lock = fuse_calibration_freeze;
      d.cal_a    = fuse_trim;
      d.cal_b    = fuse_slope;
    end
    for (int i = 0; i < 4; i++) begin
      if (!req[i]) begin
        d.gcnt[i] = 2'h0;
        d.gate[i] = 1'b0;
      end else if (!q.gate[i] && edge_v[i] &&
                   (q.r2[i] || keep[i])) begin
        d.gcnt[i] = q.gcnt[i] + 2'h1;
        d.gate[i] = (q.gcnt[i] == GATE_EDGES);
      end
    end
    // take the new source only once its gate is open
    if ((q.target != q.active) && q.gate[q.target]) begin
      d.active = q.target;
    end
    if (q.ctrl_b[PEN_BIT]) begin
      if (edge_v[q.active] && q.gate[q.active]) begin
        // >= lets a smaller ratio take effect at once
        if (q.div_cnt >= mcs_half(q.ctrl_b[4:1])) begin
          d.div_cnt  = 6'h00;
          d.per_lvl  = ~q.per_lvl;
          d.per_tick = ~q.per_lvl;
        end else begin
          d.div_cnt = q.div_cnt + 6'h01;
        end
      end
    end else begin
      d.div_cnt  = 6'h00;
      d.per_lvl  = q.s2[q.active] & q.gate[q.active];
      d.per_tick = edge_v[q.active] & q.gate[q.active];
    end
    d.pin_oe = q.ctrl_a[SYSCLOCK_PIN_OUTPUT_BIT] && (!sleep_in || sysclk_busy_in);
    d.pin    = d.pin_oe & d.per_lvl;
    d.ack = bus_req & ~q.ack;
    if (bus_req && !q.ack) begin
      unique case (idx)
        IDX_CTRL_A: d.rdata = q.ctrl_a;
        IDX_CTRL_B: d.rdata = q.ctrl_b;
        IDX_LOCK:   d.rdata = q.freeze ? 8'h00 : {7'h00, q.freeze};
        IDX_STATUS: d.rdata = {stable[SRC_EXT], stable[SRC_XTAL],
                               stable[SRC_ULP], stable[SRC_FAST], 3'h0,
                               q.target != q.active};
        IDX_FCTL:   d.rdata = q.fctl;
        IDX_CAL_A:  d.rdata = {1'b0, q.cal_a};
        IDX_CAL_B:  d.rdata = {q.cal_lock, 3'h0, q.cal_b};
        IDX_UCTL:   d.rdata = q.uctl;
        IDX_XCTL:   d.rdata = q.xctl;
        default:    d.rdata = 8'h00;
      endcase
    end
    // every finished access counts as one instruction of the window
    if (acc && (q.key_cnt != 3'h0)) begin
      d.key_cnt = q.key_cnt - 3'h1;
    end
    if (acc && avs_write) begin
      if ((idx == IDX_KEY) && (wd == PROT_KEY)) begin
        d.key_cnt = KEY_WINDOW;
      end else if (prot_ok) begin
        d.key_cnt = 3'h0;
        unique case (idx)
          IDX_CTRL_A: if (!q.freeze) begin
            d.ctrl_a = wd & CTRL_A_MSK;
            d.target = wd[1:0];
          end
          IDX_CTRL_B: if (!q.freeze) begin
            d.ctrl_b[PEN_BIT] = wd[PEN_BIT];
            if (mcs_code_ok(wd[4:1])) begin
              d.ctrl_b[4:1] = wd[4:1];
            end
          end
          IDX_LOCK: if (!q.freeze) begin
            d.freeze = wd[FREEZE_BIT];
          end
          IDX_FCTL: d.fctl = wd & RUN_MSK;
          IDX_CAL_A: if (!q.cal_lock &&
                         !(q.freeze && q.active == SRC_FAST)) begin
            d.cal_a = wd[6:0];
          end
          IDX_CAL_B: if (!q.cal_lock &&
                         !(q.freeze && q.active == SRC_FAST)) begin
            d.cal_b = wd[3:0];
          end
          IDX_UCTL: d.uctl = wd & RUN_MSK;
          IDX_XCTL: begin
            d.xctl[1:0] = wd[1:0];
            // source type and start-up time frozen while in use
            if (!q.xctl[XEN_BIT] && !q.gate[SRC_XTAL]) begin
              d.xctl = wd & XCTL_MSK;
            end
          end
          default: d.key_cnt = 3'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q        <= '0;
      q.ctrl_a <= CTRL_A_RST;
      q.ctrl_b <= CTRL_B_RST;
      q.fctl   <= OSC_RST;
      q.uctl   <= OSC_RST;
      q.xctl   <= OSC_RST;
      q.active <= SRC_FAST;
      q.target <= SRC_FAST;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_key_armed;
    acc && avs_write && idx == IDX_KEY && wd == PROT_KEY;
  endsequence
  sequence s_sel_write;
    acc && avs_write && idx == IDX_CTRL_A && prot_ok && !q.freeze;
  endsequence
  sequence s_bare_write;
    acc && avs_write && idx == IDX_CTRL_B && !prot_ok;
  endsequence

  chk_select_write: assert property (
    s_sel_write |=> q.target == $past(wd[1:0]))
    else $error("select write not taken");
  chk_key_window: assert property (
    s_key_armed |=> q.key_cnt == KEY_WINDOW)
    else $error("key did not open window");
  chk_bare_write: assert property (
    s_bare_write |=> $stable(q.ctrl_b))
    else $error("unprotected write changed register");
  chk_freeze_hold: assert property (
    q.freeze |=> $stable(q.ctrl_a) && $stable(q.ctrl_b))
    else $error("frozen control changed");
  chk_freeze_sticky: assert property (
    q.init && q.freeze |=> q.freeze [*3])
    else $error("freeze released without reset");
  chk_div_legal: assert property (
    mcs_code_ok(q.ctrl_b[4:1]))
    else $error("reserved division code held");
  chk_pass_through: assert property (
    !q.ctrl_b[PEN_BIT] && edge_v[q.active] && q.gate[q.active] ##1
    !q.ctrl_b[PEN_BIT] |-> q.per_tick)
    else $error("undivided tick missing");
  chk_switch_done: assert property (
    q.target != q.active && q.gate[q.target] |=>
    q.active == $past(q.target))
    else $error("switch not taken on stable source");
  chk_gate_open: assert property (
    $rose(q.gate[SRC_FAST]) |-> $past(q.gcnt[SRC_FAST]) == GATE_EDGES)
    else $error("gate opened early");
  chk_pin_sleep: assert property (
    sleep_in && !sysclk_busy_in |=> !q.pin_oe && !q.pin)
    else $error("clock on pin during sleep");
  chk_stable_req: assert property (
    !req[SRC_ULP] |-> !stable[SRC_ULP])
    else $error("stable without request");

  // read data is registered in the wait cycle, checked one edge later
  sequence s_read_start;
    bus_req && !q.ack && !avs_write;
  endsequence
  sequence s_ctrl_b_write;
    acc && avs_write && idx == IDX_CTRL_B && prot_ok && !q.freeze;
  endsequence

  chk_lock_read: assert property (
    s_read_start and (idx == IDX_LOCK && q.freeze) |=> q.rdata == 8'h00)
    else $error("lock register readable while frozen");
  chk_hole_read: assert property (
    s_read_start and (idx > IDX_STATUS && idx < IDX_FCTL) |=>
    q.rdata == 8'h00)
    else $error("reserved offset read nonzero");
  chk_source_switching_read: assert property (
    s_read_start and (idx == IDX_STATUS) |=>
    q.rdata[0] == $past(q.target != q.active))
    else $error("switch flag misreported");
  chk_code_kept: assert property (
    s_ctrl_b_write and (!mcs_code_ok(wd[4:1])) |=>
    q.ctrl_b[4:1] == $past(q.ctrl_b[4:1]))
    else $error("reserved division code taken");
  chk_key_used: assert property (
    s_ctrl_b_write |=> q.key_cnt == 3'h0)
    else $error("key window not closed by write");

  // prescaler idle while bypassed
  chk_bypass_cnt: assert property (
    !q.ctrl_b[PEN_BIT] |=> q.div_cnt == 6'h00)
    else $error("divider counting while bypassed");
  chk_switch_wait: assert property (
    q.target != q.active && !q.gate[q.target] |=>
    q.active == $past(q.active))
    else $error("switched before new source stable");

  chk_grant_req: assert property (
    !req[SRC_FAST] |-> !osc_grant_o[SRC_FAST])
    else $error("clock granted without request");
  chk_keep_run: assert property (
    q.fctl[KEEP_BIT] |-> osc_run_o[SRC_FAST])
    else $error("kept oscillator stopped");
  chk_gate_drop: assert property (
    !req[SRC_FAST] |=> !q.gate[SRC_FAST])
    else $error("gate left open without request");

  // pin enable follows control A one cycle late
  chk_pin_off: assert property (
    !q.ctrl_a[SYSCLOCK_PIN_OUTPUT_BIT] |=> !q.pin_oe)
    else $error("clock pin driven while disabled");
  chk_pin_on: assert property (
    q.ctrl_a[SYSCLOCK_PIN_OUTPUT_BIT] && !sleep_in |=> q.pin_oe)
    else $error("clock pin not driven");
  chk_pin_data: assert property (
    q.pin |-> q.pin_oe && q.per_lvl)
    else $error("pin level not the peripheral clock");
  chk_pin_busy: assert property (
    q.ctrl_a[SYSCLOCK_PIN_OUTPUT_BIT] && sysclk_busy_in |=> q.pin_oe)
    else $error("pin silent while clock in use");

  // fuse values are taken in the first cycle after reset
  chk_fuse_load: assert property (
    !q.init |=> q.freeze == $past(fuse_calibration_freeze))
    else $error("freeze not loaded from fuse");
  chk_cal_frozen: assert property (
    q.init && q.cal_lock |=> $stable(q.cal_a) && $stable(q.cal_b))
    else $error("calibration changed under fuse lock");

endmodule : mcs_main_clock

// [bench/mcs_osc_model.sv]
// oscillator sources seen by the clock controller
`timescale 1ns/1ps
module mcs_osc_model (
  input  wire logic [3:0] run,
  output logic      [3:0] clk,
  output logic      [3:0] ready
);
  // half periods put oscillator edges on ref_clk falling edges, off the rising edges, so syncing is repeatable
  localparam int HALF [4] = '{40, 80, 80, 60};
  localparam int START [4] = '{200, 2000, 400, 300};
  initial clk = 4'h0;
  initial ready = 4'h0;
  for (genvar i = 0; i < 4; i++) begin : g_src
    // stopped source stands low, never holds a stale level
    always begin
      #(HALF[i]);
      clk[i] = run[i] ? ~clk[i] : 1'b0;
    end
    always @(run[i]) begin
      ready[i] = 1'b0;
      if (run[i]) #(START[i]) ready[i] = run[i];
    end
  end
endmodule : mcs_osc_model

// [bench/test_main_clock_selector_prescaler.sv]
// self-checking bench for the main clock selector and prescaler
`timescale 1ns/1ps
module test_main_clock_selector_prescaler
  import mcs_pkg::*;
();
  localparam int RAT [16] = '{2,4,8,16,32,64,0,0,6,10,12,24,48,0,0,0};
  localparam int PER [4] = '{8, 16, 16, 12};
  localparam int ORD [4] = '{1, 2, 0, 3};
  localparam logic [7:0] SBIT [4] = '{8'h10, 8'h20, 8'h40, 8'h80};
  logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic        sleep_in, sysclk_busy_in, fuse_lk, per_tick, pin_oe;
  logic [7:0]  avs_address, rdv;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  periph_req, osc_clk, osc_ready, osc_run, osc_grant;
  logic [1:0]  main_src, s;
  int          errors, tests_run, gap, exp, n;

  mcs_main_clock dut (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_clk_in(osc_clk),
    .osc_ready_in(osc_ready), .periph_req(periph_req), .sleep_in(sleep_in),
    .sysclk_busy_in(sysclk_busy_in), .fuse_calibration_freeze(fuse_lk),
    .fuse_trim(7'h2a), .fuse_slope(4'h5), .osc_run_o(osc_run),
    .osc_grant_o(osc_grant), .main_src_o(main_src),
    .peripheral_clock_o(), .per_tick_o(per_tick),
    .sysclock_pin_output(), .sysclock_pin_oe(pin_oe),
    .fast_osc_trim_o(), .fast_osc_temp_slope_o(), .crystal_cfg_o());
  mcs_osc_model osc (.run(osc_run), .clk(osc_clk), .ready(osc_ready));

  always #5 ref_clk = ~ref_clk;

  task stop_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task fail(string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : fail
  task timeout();
    fail("wait limit");
    stop_test();
  endtask : timeout
  task chk_byte(logic [7:0] got, logic [7:0] want);
    tests_run++;
    if (got !== want) fail($sformatf("byte %h want %h", got, want));
  endtask : chk_byte
  task chk_bit(logic got, logic want);
    tests_run++;
    if (got !== want) fail($sformatf("bit %b want %b", got, want));
  endtask : chk_bit
  task chk_cnt(int got, int want);
    tests_run++;
    if (got != want) fail($sformatf("count %0d want %0d", got, want));
  endtask : chk_cnt
  // request held until the edge that samples waitrequest low
  task bus(logic w, logic [5:0] idx, logic [7:0] d);
    int k;
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    k = 0;
    // waitrequest and readdata are the values this edge samples
    do begin
      @(posedge ref_clk);
      k++;
      if (k > 20) timeout();
    end while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task rd(logic [5:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask : rd
  task kwr(logic [5:0] idx, logic [7:0] d);
    bus(1'b1, IDX_KEY, PROT_KEY);
    bus(1'b1, idx, d);
  endtask : kwr
  task edges(int k);
    repeat (k) @(negedge ref_clk);
  endtask : edges
  task tick_gap();
    n = 0;
    while (per_tick !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 2000) timeout();
    end
    gap = 0;
    do begin
      @(negedge ref_clk);
      gap++;
    end while (per_tick !== 1'b1 && gap < 2000);
  endtask : tick_gap
  task do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
  endtask : do_reset

  initial begin
    ref_clk = 0; reset = 1; avs_read = 0; avs_write = 0; avs_address = 0;
    avs_writedata = 0; periph_req = 0; sleep_in = 0; sysclk_busy_in = 0;
    fuse_lk = 0; errors = 0; tests_run = 0;
    do_reset();
    rd(IDX_CTRL_A); chk_byte(rdv, CTRL_A_RST);
    rd(IDX_CTRL_B); chk_byte(rdv, CTRL_B_RST);
    tick_gap(); tick_gap(); chk_cnt(gap, 6 * PER[0]);
    bus(1'b1, 6'h04, 8'hff); rd(6'h04); chk_byte(rdv, 8'h00);
    bus(1'b1, IDX_CTRL_B, 8'h03); rd(IDX_CTRL_B); chk_byte(rdv, 8'h11);
    kwr(IDX_CTRL_A, 8'h7c); rd(IDX_CTRL_A); chk_byte(rdv, 8'h00);
    // fast source keeps every ratio under the peripheral limit
    exp = 6;
    for (int c = 0; c < 16; c++) begin
      kwr(IDX_CTRL_B, {3'h7, c[3:0], 1'b1});
      if (RAT[c] != 0) begin
        exp = RAT[c];
        rd(IDX_CTRL_B); chk_byte(rdv, {3'h0, c[3:0], 1'b1});
      end
      tick_gap(); tick_gap(); chk_cnt(gap, exp * PER[0]);
    end
    kwr(IDX_CTRL_B, 8'h10); tick_gap(); tick_gap(); chk_cnt(gap, PER[0]);
    kwr(IDX_CTRL_A, 8'h80); edges(2); chk_bit(pin_oe, 1'b1);
    @(posedge ref_clk) sleep_in <= 1'b1;
    edges(3); chk_bit(pin_oe, 1'b0);
    @(posedge ref_clk) sysclk_busy_in <= 1'b1;
    edges(3); chk_bit(pin_oe, 1'b1);
    @(posedge ref_clk) sleep_in <= 1'b0;
    kwr(IDX_XCTL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      s = ORD[i][1:0];
      kwr(IDX_CTRL_A, {6'h0, s}); rd(IDX_STATUS); chk_bit(rdv[0], 1'b1);
      for (n = 0; main_src !== s && n < 1000; n++) @(negedge ref_clk);
      if (n >= 1000) timeout();
      rd(IDX_STATUS); chk_byte(rdv, SBIT[s]);
      tick_gap(); tick_gap(); chk_cnt(gap, PER[s]);
    end
    // external is main now, so the fast source has no user
    kwr(IDX_FCTL, 8'h02); edges(80); chk_bit(osc_run[0], 1'b1);
    rd(IDX_STATUS); chk_byte(rdv, 8'h80);
    chk_bit(osc_grant[0], 1'b0);
    @(posedge ref_clk) periph_req[0] <= 1'b1;
    for (n = 0; osc_grant[0] !== 1'b1 && n < 60; n++) @(negedge ref_clk);
    chk_bit(n >= 24 && n <= 40, 1'b1);
    rd(IDX_STATUS); chk_byte(rdv, 8'h90);
    kwr(IDX_LOCK, 8'h01); rd(IDX_LOCK); chk_byte(rdv, 8'h00);
    kwr(IDX_CTRL_B, 8'h03); rd(IDX_CTRL_B); chk_byte(rdv, 8'h10);
    kwr(IDX_CTRL_A, 8'h00); rd(IDX_CTRL_A); chk_byte(rdv, 8'h03);
    @(posedge ref_clk);
    fuse_lk <= 1'b1;
    periph_req <= 4'h0;
    do_reset();
    kwr(IDX_CTRL_B, 8'h03); rd(IDX_CTRL_B); chk_byte(rdv, 8'h11);
    rd(IDX_LOCK); chk_byte(rdv, 8'h00);
    stop_test();
  end
endmodule : test_main_clock_selector_prescaler
